// *** rtl/dma_evt_pkg.sv ***
// Overview of operation
// RQ1 - Dest-done flag sets when dest pointer first equals the dest size.
// RQ2 - Dest-half-full flag sets when dest pointer first equals half size.
// RQ3 - Block flag sets when bytes moved equal the larger of the two sizes.
// RQ4 - Block flag also sets when a pattern match ends the transfer.
// RQ5 - Cell flag sets each time a whole cell of bytes has been moved.
// RQ6 - A hit of the abort source aborts the transfer and sets abort flag.
// RQ7 - Address-error flag sets on an invalid source or dest address.
// RQ8 - Source-done flag sets when source pointer first equals source size.
// RQ9 - Source-half flag sets when source pointer first equals half size.
// RQ10 - A flag raises the channel interrupt only while its enable is one.
// RQ11 - Flags stay set until written to zero; interrupt is OR of enabled.
`default_nettype none

package dma_evt_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PTR_W = 16;
    localparam int FLAG_W = 8;

    localparam logic [7:0] OFF_EVT_CTRL = 8'h00;
    localparam logic [7:0] OFF_SRC_START = 8'h04;

    localparam int BIT_ADDR_ERR = 0;
    localparam int BIT_ABORT = 1;
    localparam int BIT_CELL = 2;
    localparam int BIT_BLOCK = 3;
    localparam int BIT_DEST_HALF = 4;
    localparam int BIT_DEST_DONE = 5;
    localparam int BIT_SRC_HALF = 6;
    localparam int BIT_SRC_DONE = 7;
    localparam int EN_LSB = 16;
    localparam int LANE_FLAGS = 0;
    localparam int LANE_EN = 2;

    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] EN_RST = 8'h00;
    localparam logic [31:0] SRC_START_RST = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// *** rtl/reg_access_if.sv ***
`timescale 1ns/1ns
`default_nettype none

interface reg_access_if;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic rd_stb;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;

    modport bus (output wr_stb, wr_addr, wr_data, wr_strb, rd_stb, rd_addr,
                 input wr_err, rd_data, rd_err);
    modport regs (input wr_stb, wr_addr, wr_data, wr_strb, rd_stb, rd_addr,
                  output wr_err, rd_data, rd_err);
endinterface

`default_nettype wire

// *** rtl/axil_reg_slave.sv ***
`timescale 1ns/1ns
`default_nettype none

module axil_reg_slave (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    reg_access_if.bus ra
);

    logic aw_got_ff, w_got_ff, rd_pend_ff;
    logic [7:0] waddr_ff, raddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic do_wr;

    // Both halves held until the response has been taken
    assign do_wr = aw_got_ff && w_got_ff && !bvalid;
    assign ra.wr_stb = do_wr;
    assign ra.wr_addr = waddr_ff;
    assign ra.wr_data = wdata_ff;
    assign ra.wr_strb = wstrb_ff;
    assign ra.rd_stb = rd_pend_ff;
    assign ra.rd_addr = raddr_ff;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            aw_got_ff <= 1'b0;
            awready <= 1'b0;
            waddr_ff <= 8'h00;
        end else begin
            if (awvalid && awready) begin
                aw_got_ff <= 1'b1;
                waddr_ff <= awaddr;
            end else if (do_wr) begin
                aw_got_ff <= 1'b0;
            end
            awready <= !(awvalid && awready) && !aw_got_ff && !bvalid;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            w_got_ff <= 1'b0;
            wready <= 1'b0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            if (wvalid && wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end else if (do_wr) begin
                w_got_ff <= 1'b0;
            end
            wready <= !(wvalid && wready) && !w_got_ff && !bvalid;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            bvalid <= 1'b0;
            bresp <= dma_evt_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bvalid <= 1'b1;
            bresp <= ra.wr_err ? dma_evt_pkg::RESP_SLVERR
                               : dma_evt_pkg::RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            arready <= 1'b0;
            rd_pend_ff <= 1'b0;
            raddr_ff <= 8'h00;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= dma_evt_pkg::RESP_OKAY;
        end else begin
            arready <= !(arvalid && arready) && !rd_pend_ff && !rvalid;
            rd_pend_ff <= arvalid && arready;
            if (arvalid && arready) begin
                raddr_ff <= araddr;
            end
            if (rd_pend_ff) begin
                rvalid <= 1'b1;
                rdata <= ra.rd_data;
                rresp <= ra.rd_err ? dma_evt_pkg::RESP_SLVERR
                                   : dma_evt_pkg::RESP_OKAY;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

endmodule // axil_reg_slave

`default_nettype wire

// *** rtl/level_match_detect.sv ***
`timescale 1ns/1ns
`default_nettype none

module level_match_detect (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [15:0] count,
    input wire logic [15:0] limit,
    output logic full_hit_ff,
    output logic half_hit_ff
);

    logic full_eq, half_eq, full_eq_ff, half_eq_ff;

    assign full_eq = (count == limit);
    assign half_eq = (count == (limit >> 1));

    // Equal at reset counts as already seen, so no event fires at start
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            full_eq_ff <= 1'b1;
            half_eq_ff <= 1'b1;
            full_hit_ff <= 1'b0;
            half_hit_ff <= 1'b0;
        end else begin
            full_eq_ff <= full_eq;
            half_eq_ff <= half_eq;
            full_hit_ff <= full_eq && !full_eq_ff;
            half_hit_ff <= half_eq && !half_eq_ff;
        end
    end

endmodule // level_match_detect

`default_nettype wire

// *** rtl/dma_channel_event_flags.sv ***
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module dma_channel_event_flags (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic [15:0] source_pointer,
    input wire logic [15:0] source_size,
    input wire logic [15:0] dest_pointer,
    input wire logic [15:0] dest_size,
    input wire logic [15:0] block_bytes,
    input wire logic [15:0] cell_bytes,
    input wire logic [15:0] cell_size,
    input wire logic pattern_match,
    input wire logic abort_source_hit,
    input wire logic source_addr_err,
    input wire logic dest_addr_err,
    output logic [31:0] source_start_address,
    output logic chan_abort,
    output logic chan_irq
);

    ////////////////////////////////////////////////////////////////////////

    function automatic logic reg_hit(input logic [7:0] addr,
                                     input logic [7:0] offset);
        reg_hit = (addr == offset);
    endfunction

    function automatic logic [15:0] larger_of(input logic [15:0] a,
                                              input logic [15:0] b);
        larger_of = (a > b) ? a : b;
    endfunction

    ////////////////////////////////////////////////////////////////////////

    reg_access_if ra ();

    logic [7:0] flags_ff;
    logic [7:0] en_ff;
    logic [31:0] src_start_ff;
    logic chan_irq_ff;
    logic chan_abort_ff;
    logic [7:0] evt_set;
    logic [15:0] block_limit;
    logic src_done_hit, src_half_hit;
    logic dest_done_hit, dest_half_hit;
    logic block_hit, cell_hit;
    logic wr_ctrl, wr_start, rd_ctrl, rd_start;
    logic flag_wr, en_wr;

    axil_reg_slave u_bus (
        .mclk(mclk),
        .rstn(rstn),
        .awvalid(awvalid),
        .awready(awready),
        .awaddr(awaddr),
        .wvalid(wvalid),
        .wready(wready),
        .wdata(wdata),
        .wstrb(wstrb),
        .bvalid(bvalid),
        .bready(bready),
        .bresp(bresp),
        .arvalid(arvalid),
        .arready(arready),
        .araddr(araddr),
        .rvalid(rvalid),
        .rready(rready),
        .rdata(rdata),
        .rresp(rresp),
        .ra(ra.bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // Event detection

    level_match_detect u_src (
        .mclk(mclk),
        .rstn(rstn),
        .count(source_pointer),
        .limit(source_size),
        .full_hit_ff(src_done_hit), // [RQ8]
        .half_hit_ff(src_half_hit) // [RQ9]
    );

    level_match_detect u_dest (
        .mclk(mclk),
        .rstn(rstn),
        .count(dest_pointer),
        .limit(dest_size),
        .full_hit_ff(dest_done_hit), // [RQ1]
        .half_hit_ff(dest_half_hit) // [RQ2]
    );

    assign block_limit = larger_of(source_size, dest_size); // [RQ3]

    level_match_detect u_block (
        .mclk(mclk),
        .rstn(rstn),
        .count(block_bytes),
        .limit(block_limit),
        .full_hit_ff(block_hit), // [RQ3]
        .half_hit_ff()
    );

    level_match_detect u_cell (
        .mclk(mclk),
        .rstn(rstn),
        .count(cell_bytes),
        .limit(cell_size),
        .full_hit_ff(cell_hit), // [RQ5]
        .half_hit_ff()
    );

    always_comb begin
        evt_set = dma_evt_pkg::FLAGS_RST;
        evt_set[dma_evt_pkg::BIT_SRC_DONE] = src_done_hit; // [RQ8]
        evt_set[dma_evt_pkg::BIT_SRC_HALF] = src_half_hit; // [RQ9]
        evt_set[dma_evt_pkg::BIT_DEST_DONE] = dest_done_hit; // [RQ1]
        evt_set[dma_evt_pkg::BIT_DEST_HALF] = dest_half_hit; // [RQ2]
        // Pattern match ends the block early
        evt_set[dma_evt_pkg::BIT_BLOCK] = block_hit || pattern_match; // [RQ4]
        evt_set[dma_evt_pkg::BIT_CELL] = cell_hit; // [RQ5]
        evt_set[dma_evt_pkg::BIT_ABORT] = abort_source_hit; // [RQ6]
        evt_set[dma_evt_pkg::BIT_ADDR_ERR] =
            source_addr_err || dest_addr_err; // [RQ7]
    end

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    assign wr_ctrl = ra.wr_stb && reg_hit(ra.wr_addr, dma_evt_pkg::OFF_EVT_CTRL);
    assign wr_start = ra.wr_stb
                      && reg_hit(ra.wr_addr, dma_evt_pkg::OFF_SRC_START);
    assign rd_ctrl = reg_hit(ra.rd_addr, dma_evt_pkg::OFF_EVT_CTRL);
    assign rd_start = reg_hit(ra.rd_addr, dma_evt_pkg::OFF_SRC_START);
    assign flag_wr = wr_ctrl && ra.wr_strb[dma_evt_pkg::LANE_FLAGS];
    assign en_wr = wr_ctrl && ra.wr_strb[dma_evt_pkg::LANE_EN];
    assign ra.wr_err = !reg_hit(ra.wr_addr, dma_evt_pkg::OFF_EVT_CTRL)
                       && !reg_hit(ra.wr_addr, dma_evt_pkg::OFF_SRC_START);
    assign ra.rd_err = !rd_ctrl && !rd_start;

    always_comb begin
        ra.rd_data = 32'h0000_0000;
        if (rd_ctrl) begin
            ra.rd_data[dma_evt_pkg::FLAG_W-1:0] = flags_ff;
            ra.rd_data[dma_evt_pkg::EN_LSB +: dma_evt_pkg::FLAG_W] = en_ff;
        end else if (rd_start) begin
            ra.rd_data = src_start_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags: a zero written clears, a same-cycle event wins

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            flags_ff <= dma_evt_pkg::FLAGS_RST;
        end else if (flag_wr) begin
            flags_ff <= (flags_ff & ra.wr_data[dma_evt_pkg::FLAG_W-1:0])
                        | evt_set; // [RQ11]
        end else begin
            flags_ff <= flags_ff | evt_set; // [RQ11]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            en_ff <= dma_evt_pkg::EN_RST;
        end else if (en_wr) begin
            en_ff <= ra.wr_data[dma_evt_pkg::EN_LSB +: dma_evt_pkg::FLAG_W];
        end
    end

    // Each byte lane written on its own
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            src_start_ff <= dma_evt_pkg::SRC_START_RST;
        end else if (wr_start) begin
            for (int i = 0; i < 4; i++) begin
                if (ra.wr_strb[i]) begin
                    src_start_ff[8*i +: 8] <= ra.wr_data[8*i +: 8];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt and abort outputs

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            chan_irq_ff <= 1'b0;
        end else begin
            chan_irq_ff <= |(flags_ff & en_ff); // [RQ10] [RQ11]
        end
    end

    // Abort to the transfer engine: abort_source_hit delayed one cycle, high as long as it is
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            chan_abort_ff <= 1'b0;
        end else begin
            chan_abort_ff <= abort_source_hit; // [RQ6]
        end
    end

    assign chan_irq = chan_irq_ff;
    assign chan_abort = chan_abort_ff;
    assign source_start_address = src_start_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    property p_dest_done;
        $past(rstn) && dest_pointer == dest_size
            && $past(dest_pointer) != $past(dest_size)
        |-> ##2 flags_ff[dma_evt_pkg::BIT_DEST_DONE];
    endproperty
    a_dest_done: assert property (p_dest_done) // [RQ1]
        else $error("dest done flag not set");

    property p_dest_half;
        $past(rstn) && dest_pointer == (dest_size >> 1)
            && $past(dest_pointer) != ($past(dest_size) >> 1)
        |-> ##2 flags_ff[dma_evt_pkg::BIT_DEST_HALF];
    endproperty
    a_dest_half: assert property (p_dest_half) // [RQ2]
        else $error("dest half flag not set");

    property p_block_done;
        $past(rstn) && block_bytes == block_limit
            && $past(block_bytes) != $past(block_limit)
        |-> ##2 flags_ff[dma_evt_pkg::BIT_BLOCK];
    endproperty
    a_block_done: assert property (p_block_done) // [RQ3]
        else $error("block flag not set on full block");

    property p_block_pattern;
        pattern_match |=> flags_ff[dma_evt_pkg::BIT_BLOCK];
    endproperty
    a_block_pattern: assert property (p_block_pattern) // [RQ4]
        else $error("block flag not set on pattern match");

    property p_cell_done;
        $past(rstn) && cell_bytes == cell_size
            && $past(cell_bytes) != $past(cell_size)
        |-> ##2 flags_ff[dma_evt_pkg::BIT_CELL];
    endproperty
    a_cell_done: assert property (p_cell_done) // [RQ5]
        else $error("cell flag not set");

    property p_abort;
        abort_source_hit
        |=> flags_ff[dma_evt_pkg::BIT_ABORT] && chan_abort_ff
            ##1 !chan_abort_ff || $past(abort_source_hit);
    endproperty
    a_abort: assert property (p_abort) // [RQ6]
        else $error("abort not flagged or pulse wrong");

    property p_addr_err;
        source_addr_err || dest_addr_err
        |=> flags_ff[dma_evt_pkg::BIT_ADDR_ERR];
    endproperty
    a_addr_err: assert property (p_addr_err) // [RQ7]
        else $error("address error flag not set");

    property p_src_done;
        $past(rstn) && source_pointer == source_size
            && $past(source_pointer) != $past(source_size)
        |-> ##2 flags_ff[dma_evt_pkg::BIT_SRC_DONE];
    endproperty
    a_src_done: assert property (p_src_done) // [RQ8]
        else $error("source done flag not set");

    property p_src_half;
        $past(rstn) && source_pointer == (source_size >> 1)
            && $past(source_pointer) != ($past(source_size) >> 1)
        |-> ##2 flags_ff[dma_evt_pkg::BIT_SRC_HALF];
    endproperty
    a_src_half: assert property (p_src_half) // [RQ9]
        else $error("source half flag not set");

    property p_irq_masked;
        (flags_ff & en_ff) == 8'h00 |=> !chan_irq_ff;
    endproperty
    a_irq_masked: assert property (p_irq_masked) // [RQ10]
        else $error("interrupt raised with no enabled flag");

    property p_irq_or;
        (flags_ff & en_ff) != 8'h00 |=> chan_irq_ff;
    endproperty
    a_irq_or: assert property (p_irq_or) // [RQ11]
        else $error("interrupt missing for enabled flag");

    property p_en_hold;
        !en_wr |=> $stable(en_ff);
    endproperty
    a_en_hold: assert property (p_en_hold) // [RQ10]
        else $error("enable bits changed without a write");

    property p_flag_sticky;
        !flag_wr |=> ($past(flags_ff) & ~flags_ff) == 8'h00;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // [RQ11]
        else $error("flag dropped without a write");

    property p_flag_clear;
        flag_wr && ra.wr_data[7:0] == 8'h00 && evt_set == 8'h00
        |=> flags_ff == 8'h00;
    endproperty
    a_flag_clear: assert property (p_flag_clear) // [RQ11]
        else $error("flags not cleared by zero write");

    c_irq_rise: cover property ($rose(chan_irq_ff));
    c_abort: cover property (abort_source_hit ##1 chan_abort_ff);
    c_pattern: cover property (pattern_match && !block_hit);
    c_clear_race: cover property (flag_wr && evt_set != 8'h00);
    c_masked: cover property (flags_ff != 8'h00 && !chan_irq_ff);

endmodule // dma_channel_event_flags

`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none

module testbench;
    logic mclk, rstn;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, source_start_address;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [15:0] source_pointer, source_size, dest_pointer, dest_size;
    logic [15:0] block_bytes, cell_bytes, cell_size;
    logic pattern_match, abort_source_hit, source_addr_err, dest_addr_err;
    logic chan_abort, chan_irq;
    int num_errors = 0;
    int check_count = 0;
    logic [31:0] rd;
    logic [1:0] rsp;
    int abort_cnt;

    dma_channel_event_flags i_dut (
        .mclk(mclk), .rstn(rstn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .source_pointer(source_pointer), .source_size(source_size),
        .dest_pointer(dest_pointer), .dest_size(dest_size),
        .block_bytes(block_bytes), .cell_bytes(cell_bytes),
        .cell_size(cell_size), .pattern_match(pattern_match),
        .abort_source_hit(abort_source_hit),
        .source_addr_err(source_addr_err), .dest_addr_err(dest_addr_err),
        .source_start_address(source_start_address),
        .chan_abort(chan_abort), .chan_irq(chan_irq)
    );

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Both channels offered together, each released on its own handshake
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        bit aw_done;
        bit w_done;
        int n;
        aw_done = 0;
        w_done = 0;
        n = 0;
        @(posedge mclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        bready <= 1'b1;
        while (!(aw_done && w_done) && n < 100) begin
            @(posedge mclk);
            n++;
            if (!aw_done && awready) begin
                aw_done = 1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1;
                wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge mclk);
            n++;
        end while (bvalid !== 1'b1 && n < 200);
        if (n >= 200) num_errors++;
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (arready !== 1'b1 && n < 100);
        arvalid <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
        end while (rvalid !== 1'b1 && n < 200);
        if (n >= 200) num_errors++;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Index 10 is a block count below the larger size: no flag expected
    function automatic logic [7:0] event_bit(input int i);
        if (i < 8) return 8'h01 << i;
        if (i == 8) return 8'h08;
        if (i == 9) return 8'h01;
        return 8'h00;
    endfunction

    task automatic fire(input int i);
        @(posedge mclk);
        case (i)
            0: source_addr_err <= 1'b1;
            1: abort_source_hit <= 1'b1;
            2: cell_bytes <= 16'h0004;
            3: block_bytes <= 16'h0020;
            4: dest_pointer <= 16'h0010;
            5: dest_pointer <= 16'h0020;
            6: source_pointer <= 16'h0008;
            7: source_pointer <= 16'h0010;
            8: pattern_match <= 1'b1;
            9: dest_addr_err <= 1'b1;
            default: block_bytes <= 16'h0010;
        endcase
        @(posedge mclk);
        {source_addr_err, dest_addr_err} <= 2'b00;
        {abort_source_hit, pattern_match} <= 2'b00;
        source_pointer <= 16'h0000;
        dest_pointer <= 16'h0000;
        block_bytes <= 16'h0000;
        cell_bytes <= 16'h0000;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'h0;
        {source_pointer, dest_pointer} = 32'h0000_0000;
        source_size = 16'h0010;
        dest_size = 16'h0020;
        {block_bytes, cell_bytes} = 32'h0000_0000;
        cell_size = 16'h0004;
        {pattern_match, abort_source_hit} = 2'b00;
        {source_addr_err, dest_addr_err} = 2'b00;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        axi_read(8'h00, rd, rsp);
        check("ctrl reset", rd, 32'h0000_0000);
        check("ctrl rresp", {30'h0, rsp}, 32'h0000_0000);
        axi_read(8'h04, rd, rsp);
        check("start reset", rd, 32'h0000_0000);
        axi_write(8'h04, 32'hA5C3_1E70, 4'hF, rsp);
        check("start bresp", {30'h0, rsp}, 32'h0000_0000);
        axi_write(8'h04, 32'hFFFF_FFFF, 4'h2, rsp);
        axi_read(8'h04, rd, rsp);
        check("start lanes", rd, 32'hA5C3_FF70);
        check("start port", source_start_address, 32'hA5C3_FF70);
        axi_write(8'h08, 32'h1234_5678, 4'hF, rsp);
        check("unmapped bresp", {30'h0, rsp}, 32'h0000_0002);
        axi_read(8'h08, rd, rsp);
        check("unmapped rdata", rd, 32'h0000_0000);
        check("unmapped rresp", {30'h0, rsp}, 32'h0000_0002);
        // Ones to flags must not set them; lanes 1 and 3 hold nothing
        axi_write(8'h00, 32'hFFFF_FFFF, 4'hF, rsp);
        axi_read(8'h00, rd, rsp);
        check("ctrl enables", rd, 32'h00FF_0000);
        check("irq idle", {31'h0, chan_irq}, 32'h0000_0000);
        for (int i = 0; i < 11; i++) begin
            abort_cnt = 0;
            fire(i);
            repeat (4) begin
                @(posedge mclk);
                abort_cnt += int'(chan_abort === 1'b1);
            end
            check("abort pulses", abort_cnt, (i == 1) ? 1 : 0);
            axi_read(8'h00, rd, rsp);
            check("event flag", rd, {24'h00FF_00, event_bit(i)});
            check("irq on event", {31'h0, chan_irq},
                  {31'h0, |event_bit(i)});
            axi_write(8'h00, 32'h0000_0000, 4'h1, rsp);
            repeat (2) @(posedge mclk);
            axi_read(8'h00, rd, rsp);
            check("flag cleared", rd, 32'h00FF_0000);
            check("irq cleared", {31'h0, chan_irq}, 32'h0000_0000);
        end
        // Larger source size: a count equal to the dest size is no block
        @(posedge mclk);
        source_size <= 16'h0040;
        fire(3);
        repeat (4) @(posedge mclk);
        axi_read(8'h00, rd, rsp);
        check("block below max", rd, 32'h00FF_0000);
        source_size <= 16'h0010;
        // Masked event stays pending and raises the request once enabled
        axi_write(8'h00, 32'h0001_0000, 4'h4, rsp);
        fire(7);
        repeat (4) @(posedge mclk);
        check("irq masked", {31'h0, chan_irq}, 32'h0000_0000);
        axi_read(8'h00, rd, rsp);
        check("masked flag", rd, 32'h0001_0080);
        axi_write(8'h00, 32'h0080_00FF, 4'h5, rsp);
        repeat (2) @(posedge mclk);
        check("irq unmasked", {31'h0, chan_irq}, 32'h0000_0001);
        axi_read(8'h00, rd, rsp);
        check("flag kept", rd, 32'h0080_0080);
        axi_write(8'h00, 32'h0000_0000, 4'h1, rsp);
        repeat (2) @(posedge mclk);
        check("irq dropped", {31'h0, chan_irq}, 32'h0000_0000);
        give_verdict();
    end

    // Whole sequence needs a few thousand cycles at most
    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end
endmodule // testbench

`default_nettype wire
